// ==== pkg/spr_pkg.sv ====
// Shared constants and types for the speed pulse rescaler
package spr_pkg;
   // Clock and edge timing grid
   localparam int CLK_NS = 50;
   localparam int TICK_NS = 2000;
   localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
   localparam int SAMPLE_MS = 30;
   localparam int SAMPLE_TICKS = SAMPLE_MS * 1000000 / TICK_NS;
   // Widths
   localparam int PPM_W = 16;
   localparam int PER_W = 24;
   localparam int RPM_W = 14;
   localparam int PPR_W = 13;
   localparam int MPH_W = 16;
   localparam int SINC_W = 25;
   localparam int TINC_W = 28;
   // Speedometer output scaling
   localparam logic [40:0] SPD_OUT_PPM = 41'h0_0000_7530; // 30,000
   localparam logic [SINC_W-1:0] SPD_HALF = 25'h100_0000;
   localparam logic [40:0] SPD_NUM =
      41'(2) * SPD_OUT_PPM * 41'(SPD_HALF);
   // Speed in tenths of mph: 36000 s*0.1/h over tick period
   localparam logic [40:0] MPH_NUM = 41'h004_30E2_3400; // 1.8e10
   localparam logic [MPH_W-1:0] MPH_MIN_X10 = 16'h000F; // 1.5 mph
   // Tachometer scaling, rate in tenths of pulses per revolution
   localparam logic [TINC_W-1:0] TACH_HALF = 28'h8F0_D180; // 1.5e8
   localparam logic [PPR_W-1:0] PPR_RST_X10 = 13'h053C; // 134.0
   localparam logic [PPR_W-1:0] PPR_MIN_X10 = 13'h0078; // 12.0
   localparam logic [PPR_W-1:0] PPR_MAX_X10 = 13'h1388; // 500.0
   // True and complement line pair
   typedef struct packed {
      logic pos;
      logic neg;
   } spr_pair_s;
endpackage : spr_pkg

// ==== hw/spr_pulse_gen.sv ====
// Phase accumulator square wave generator with complement line
`timescale 1ns/10ps
module spr_pulse_gen
   import spr_pkg::*;
#(
   parameter int INC_W = 28,
   parameter logic [INC_W-1:0] HALF = '1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   // Timing grid and rate
   input wire logic tick,
   input wire logic [INC_W-1:0] inc,
   // Output pair
   output spr_pair_s pair
);
   logic [INC_W:0] acc_r;
   logic [INC_W:0] acc_nxt;
   logic lvl_r;
   logic lvl_nxt;
   logic [INC_W:0] sum;

   // Advance phase per tick, toggle at each half period
   always_comb begin
      sum = acc_r + {1'b0, inc};
      acc_nxt = acc_r;
      lvl_nxt = lvl_r;
      if (inc == '0) begin
         acc_nxt = '0;
         lvl_nxt = 1'b0;
      end else if (tick) begin
         if (sum >= {1'b0, HALF}) begin
            acc_nxt = sum - {1'b0, HALF};
            lvl_nxt = ~lvl_r;
         end else begin
            acc_nxt = sum;
         end
      end
   end

   // Registers; complement built from the same next-state value lvl_nxt
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         acc_r <= '0;
         lvl_r <= 1'b0;
         pair <= '{pos: 1'b0, neg: 1'b1};
      end else if (ce) begin
         acc_r <= acc_nxt;
         lvl_r <= lvl_nxt;
         pair <= '{pos: lvl_nxt, neg: ~lvl_nxt};
      end
   end
endmodule : spr_pulse_gen

// ==== hw/spr_rescaler.sv ====
// Vehicle speed measurement, speedometer and tachometer pulse drivers
`timescale 1ns/10ps
module spr_rescaler
   import spr_pkg::*;
#(
   parameter int SAMPLE_TICKS_P = SAMPLE_TICKS,
   parameter int TICK_CYC_P = TICK_CYC
) (
   // Clock, reset and enable
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   // Vehicle speed sensor, squared and synchronous
   input wire logic vss_in,
   // Calibration and engine speed
   input wire logic [PPM_W-1:0] vss_ppm,
   input wire logic [RPM_W-1:0] eng_rpm,
   input wire logic [PPR_W-1:0] tach_ppr_x10,
   input wire logic tach_ppr_load,
   // Gauge outputs
   output spr_pair_s spdo,
   output spr_pair_s tacho,
   // Status
   output logic [MPH_W-1:0] speed_mph_x10,
   output logic [PPR_W-1:0] tach_ppr_cur
);
   localparam int TCNT_W = $clog2(TICK_CYC_P + 1);
   localparam int SCNT_W = $clog2(SAMPLE_TICKS_P + 1);
   localparam logic [TCNT_W-1:0] TICK_LAST = TCNT_W'(TICK_CYC_P - 1);
   localparam logic [SCNT_W-1:0] SAMP_LAST = SCNT_W'(SAMPLE_TICKS_P - 1);
   localparam logic [PER_W-1:0] PER_SAT = '1;

   // Timing grid state
   logic [TCNT_W-1:0] tcnt_r;
   logic [TCNT_W-1:0] tcnt_nxt;
   logic tick;
   logic [SCNT_W-1:0] scnt_r;
   logic [SCNT_W-1:0] scnt_nxt;
   logic sample;

   // Input measurement state
   logic vss_prev_r;
   logic vss_prev_nxt;
   logic [1:0] edges_r;
   logic [1:0] edges_nxt;
   logic [PER_W-1:0] since_r;
   logic [PER_W-1:0] since_nxt;
   logic [PER_W-1:0] per_r;
   logic [PER_W-1:0] per_nxt;
   logic rise;

   // Speed conversion state
   logic [MPH_W-1:0] mph_r;
   logic [MPH_W-1:0] mph_nxt;
   logic [SINC_W-1:0] sinc_r;
   logic [SINC_W-1:0] sinc_nxt;
   logic [PER_W-1:0] eff_per;
   logic [40:0] prod;
   logic [40:0] mph_q;
   logic [40:0] sinc_q;

   // Tachometer state
   logic [PPR_W-1:0] ppr_r;
   logic [PPR_W-1:0] ppr_nxt;
   logic [TINC_W-1:0] tinc_r;
   logic [TINC_W-1:0] tinc_nxt;

   // 2 us tick and 30 ms sample strobe
   always_comb begin
      tick = (tcnt_r == TICK_LAST);
      tcnt_nxt = tick ? '0 : tcnt_r + 1'b1;
      sample = tick && (scnt_r == SAMP_LAST);
      scnt_nxt = scnt_r;
      if (tick) begin
         scnt_nxt = sample ? '0 : scnt_r + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tcnt_r <= '0;
         scnt_r <= '0;
      end else if (ce) begin
         tcnt_r <= tcnt_nxt;
         scnt_r <= scnt_nxt;
      end
   end

   // Period between rising edges counted in 2 us ticks
   always_comb begin
      rise = vss_in && !vss_prev_r;
      vss_prev_nxt = vss_in;
      edges_nxt = edges_r;
      since_nxt = since_r;
      per_nxt = per_r;
      if (tick && edges_r != 2'b00 && since_r != PER_SAT) begin
         since_nxt = since_r + 1'b1;
      end
      if (rise) begin
         if (edges_r != 2'b11) begin
            edges_nxt = edges_r + 1'b1;
         end
         if (edges_r != 2'b00) begin
            per_nxt = since_nxt;
         end
         since_nxt = '0;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         vss_prev_r <= 1'b0;
         edges_r <= '0;
         since_r <= '0;
         per_r <= '0;
      end else if (ce) begin
         vss_prev_r <= vss_prev_nxt;
         edges_r <= edges_nxt;
         since_r <= since_nxt;
         per_r <= per_nxt;
      end
   end

   // Speed and speedometer rate, refreshed at each sample
   always_comb begin
      // A stalled input lengthens the period so speed decays
      eff_per = (since_r > per_r) ? since_r : per_r;
      prod = 41'(vss_ppm) * 41'(eff_per);
      mph_q = '0;
      sinc_q = '0;
      if (prod != '0) begin
         mph_q = MPH_NUM / prod;
         sinc_q = SPD_NUM / prod;
      end
      mph_nxt = mph_r;
      sinc_nxt = sinc_r;
      if (sample) begin
         if (edges_r < 2'b10 || mph_q < 41'(MPH_MIN_X10)) begin
            mph_nxt = '0;
            sinc_nxt = '0;
         end else begin
            mph_nxt = (mph_q > 41'(16'hFFFF)) ? 16'hFFFF
                    : mph_q[MPH_W-1:0];
            // Rate limited below one toggle per tick
            sinc_nxt = (sinc_q >= 41'(SPD_HALF)) ? SPD_HALF - 1'b1
                     : sinc_q[SINC_W-1:0];
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         mph_r <= '0;
         sinc_r <= '0;
         speed_mph_x10 <= '0;
      end else if (ce) begin
         mph_r <= mph_nxt;
         sinc_r <= sinc_nxt;
         speed_mph_x10 <= mph_nxt;
      end
   end

   // Tachometer calibration and exact rate increment
   always_comb begin
      ppr_nxt = ppr_r;
      if (tach_ppr_load && tach_ppr_x10 >= PPR_MIN_X10
          && tach_ppr_x10 <= PPR_MAX_X10) begin
         ppr_nxt = tach_ppr_x10;
      end
      // No rounding in the increment keeps error far under 5 rpm
      tinc_nxt = TINC_W'(eng_rpm) * TINC_W'(ppr_r);
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ppr_r <= PPR_RST_X10;
         tinc_r <= '0;
         tach_ppr_cur <= PPR_RST_X10;
      end else if (ce) begin
         ppr_r <= ppr_nxt;
         tinc_r <= tinc_nxt;
         tach_ppr_cur <= ppr_nxt;
      end
   end

   // Speedometer line pair
   spr_pulse_gen #(
      .INC_W(SINC_W),
      .HALF(SPD_HALF)
   ) u_spdo (
      .clk(clk),
      .nrst(nrst),
      .ce(ce),
      .tick(tick),
      .inc(sinc_r),
      .pair(spdo)
   );

   // Tachometer line pair
   spr_pulse_gen #(
      .INC_W(TINC_W),
      .HALF(TACH_HALF)
   ) u_tacho (
      .clk(clk),
      .nrst(nrst),
      .ce(ce),
      .tick(tick),
      .inc(tinc_r),
      .pair(tacho)
   );
endmodule : spr_rescaler

// ==== tb/spr_rescaler_monitor.sv ====
// Port checker for the speed pulse rescaler, bound to the top module
`timescale 1ns/10ps
module spr_rescaler_monitor
   import spr_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   // Sensor, calibration and engine speed
   input wire logic vss_in,
   input wire logic [PPM_W-1:0] vss_ppm,
   input wire logic [RPM_W-1:0] eng_rpm,
   input wire logic [PPR_W-1:0] tach_ppr_x10,
   input wire logic tach_ppr_load,
   // Gauge pairs and status
   input wire spr_pair_s spdo,
   input wire spr_pair_s tacho,
   input wire logic [MPH_W-1:0] speed_mph_x10,
   input wire logic [PPR_W-1:0] tach_ppr_cur
);
   logic in_rng;
   // Load value inside the accepted tenths range
   assign in_rng = tach_ppr_x10 >= PPR_MIN_X10 && tach_ppr_x10 <= PPR_MAX_X10;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   chk_spd_compl: assert property (spdo.neg == !spdo.pos)
      else $error("speedometer lines not complementary");
   chk_tach_compl: assert property (tacho.neg == !tacho.pos)
      else $error("tachometer lines not complementary");
   chk_ppr_take: assert property (ce && tach_ppr_load && in_rng |=>
      tach_ppr_cur == $past(tach_ppr_x10))
      else $error("valid tach setting not taken");
   chk_ppr_refuse: assert property (tach_ppr_load && !in_rng |=>
      $stable(tach_ppr_cur))
      else $error("out of range tach setting taken");
   chk_ppr_keep: assert property (!tach_ppr_load |=>
      $stable(tach_ppr_cur))
      else $error("tach setting changed without load");
   chk_ppr_range: assert property (tach_ppr_cur >= PPR_MIN_X10 &&
      tach_ppr_cur <= PPR_MAX_X10)
      else $error("tach setting outside range");
   chk_slow_zero: assert property (speed_mph_x10 == 0 ||
      speed_mph_x10 >= MPH_MIN_X10)
      else $error("speed below threshold not forced to zero");
   chk_tach_still: assert property ((eng_rpm == 0)[*4] |=>
      $stable(tacho.pos))
      else $error("tachometer toggles at zero engine speed");
   chk_rst_out: assert property ($rose(nrst) |-> !spdo.pos &&
      !tacho.pos && speed_mph_x10 == 0 && tach_ppr_cur == PPR_RST_X10)
      else $error("outputs not at reset values after reset");
endmodule : spr_rescaler_monitor

bind spr_rescaler spr_rescaler_monitor i_mon (.clk(clk), .nrst(nrst),
   .ce(ce), .vss_in(vss_in), .vss_ppm(vss_ppm), .eng_rpm(eng_rpm),
   .tach_ppr_x10(tach_ppr_x10), .tach_ppr_load(tach_ppr_load),
   .spdo(spdo), .tacho(tacho), .speed_mph_x10(speed_mph_x10),
   .tach_ppr_cur(tach_ppr_cur));

// ==== tb/spr_vss_model.sv ====
// Speed sensor model making a squared pulse train
`timescale 1ns/10ps
module spr_vss_model (
   // Clock and control
   input wire logic clk,
   input wire logic run,
   input wire logic [15:0] per_cyc,
   // Sensor line
   output logic vss
);
   logic [15:0] cnt = 16'h0000;
   // Square wave of per_cyc cycles, line idles low while stopped
   always @(negedge clk) begin
      if (!run) begin
         cnt <= 16'h0000;
         vss <= 1'b0;
      end else begin
         cnt <= (cnt + 16'h0001 >= per_cyc) ? 16'h0000 : cnt + 16'h0001;
         vss <= cnt < (per_cyc >> 1);
      end
   end
endmodule : spr_vss_model

// ==== tb/spr_rescaler_test.sv ====
// Self-checking testbench for the speed pulse rescaler
`timescale 1ns/10ps
module spr_rescaler_test;
   import spr_pkg::*;
   localparam int TC = 4;
   localparam int ST = 50;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic ce = 1'b1;
   logic vss_in;
   logic [PPM_W-1:0] ppm = 16'hEA60;
   logic [RPM_W-1:0] rpm = 14'h0000;
   logic [PPR_W-1:0] ppr = 13'h0000;
   logic ld = 1'b0;
   logic run = 1'b0;
   spr_pair_s spdo;
   spr_pair_s tacho;
   logic [MPH_W-1:0] speed;
   logic [PPR_W-1:0] ppr_cur;
   int error_cnt = 0;
   int checks_done = 0;
   int cyc = 0;
   always #25 clk = ~clk;
   // 400 cycles per pulse is 100 ticks, 5 kHz on the real grid
   spr_vss_model i_vss (.clk(clk), .run(run), .per_cyc(16'h0190),
      .vss(vss_in));
   spr_rescaler #(.SAMPLE_TICKS_P(ST), .TICK_CYC_P(TC)) i_dut (.clk(clk),
      .nrst(nrst), .ce(ce), .vss_in(vss_in), .vss_ppm(ppm), .eng_rpm(rpm),
      .tach_ppr_x10(ppr), .tach_ppr_load(ld), .spdo(spdo), .tacho(tacho),
      .speed_mph_x10(speed), .tach_ppr_cur(ppr_cur));
   // Verdict and end of run
   task automatic give_verdict();
      if (error_cnt == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : give_verdict
   // Report and count one mismatch
   task automatic fail(input string msg);
      $display("Error at %0t: %s", $time, msg);
      error_cnt++;
   endtask : fail
   // Rising edges of one true line over a number of cycles
   task automatic rises(input bit tach, input int n, output int k);
      logic prev;
      logic cur;
      k = 0;
      prev = tach ? tacho.pos : spdo.pos;
      repeat (n) begin
         @(negedge clk);
         cur = tach ? tacho.pos : spdo.pos;
         if (cur === 1'b1 && prev === 1'b0) k++;
         prev = cur;
      end
   endtask : rises
   // Values right after reset
   task automatic t_reset();
      checks_done++;
      if (ppr_cur !== PPR_RST_X10) fail("tach setting after reset");
      checks_done++;
      if (speed !== 16'h0000 || spdo !== 2'b01 || tacho !== 2'b01)
         fail("outputs after reset");
   endtask : t_reset
   // Back-to-back loads at and beyond both range ends
   task automatic t_load();
      logic [PPR_W-1:0] v [4] = '{13'h0078, 13'h0077, 13'h1389, 13'h1388};
      logic [PPR_W-1:0] e [4] = '{13'h0078, 13'h0078, 13'h0078, 13'h1388};
      for (int i = 0; i < 4; i++) begin
         ppr = v[i];
         ld = 1'b1;
         @(negedge clk);
         checks_done++;
         if (ppr_cur !== e[i]) fail("tach setting after load");
      end
      ld = 1'b0;
   endtask : t_load
   // Tach rate from the eng_rpm input, then standstill
   task automatic t_tach();
      int k;
      rpm = 14'h1770;
      repeat (20) @(negedge clk);
      rises(1'b1, 400, k);
      checks_done++;
      if (k < 9 || k > 11) fail("tach pulse count");
      // Clock enable low freezes the tick grid and the line pair
      ce = 1'b0;
      rises(1'b1, 100, k);
      checks_done++;
      if (k != 0) fail("tach pulses with clock enable low");
      ce = 1'b1;
      rpm = 14'h0000;
      repeat (10) @(negedge clk);
      rises(1'b1, 200, k);
      checks_done++;
      if (k != 0) fail("tach pulses at zero engine speed");
   endtask : t_tach
   // Speed and speedometer rate for two calibrations
   task automatic t_speed();
      int k;
      int ex;
      run = 1'b1;
      for (int i = 1; i <= 2; i++) begin
         ppm = 16'(60000 / i);
         // 100 tick period: 1.8e10 / (ppm * 100) tenths of mph
         ex = 3000 * i;
         repeat (5 * ST * TC) @(negedge clk);
         checks_done++;
         if ($isunknown(speed) || speed < ex - ex / 10
               || speed > ex + ex / 10) fail("measured speed");
         // One output pulse per 800 cycles at the first calibration
         rises(1'b0, 8000, k);
         checks_done++;
         if (k < 10 * i - 1 || k > 10 * i + 1)
            fail("speedometer pulse count");
      end
      run = 1'b0;
   endtask : t_speed
   // Reset in mid-run returns outputs and setting to defaults
   task automatic t_rerun();
      nrst = 1'b0;
      repeat (2) @(negedge clk);
      t_reset();
      nrst = 1'b1;
      @(negedge clk);
      t_reset();
   endtask : t_rerun
   // Cycle ceiling against a hang
   always @(posedge clk) begin
      cyc++;
      if (cyc == 25000) begin
         error_cnt++;
         give_verdict();
      end
   end
   // Main sequence
   initial begin
      repeat (8) @(negedge clk);
      nrst = 1'b1;
      @(negedge clk);
      t_reset();
      t_load();
      t_tach();
      t_speed();
      t_rerun();
      give_verdict();
   end
endmodule : spr_rescaler_test
